/* rtl/uie_top.sv */
// Interrupt-enable, divisor-high and FIFO-control register block of the second UART, on classic Wishbone.
//
// Behaviour
// - Divisor high byte shares enable address under access bit.
// - Bit 7 enables programmable tx-empty interrupt mode.
// - Bit 3 enables modem status interrupt, fourth priority.
// - Bit 2 enables line status interrupt, top priority.
// - Bit 1 enables tx-holding-empty interrupt, third priority.
// - Bit 0 enables data-available and timeout, second.
// - Bits 6:4 hold divisor only under access bit.
// - FIFO status reads 00 disabled, 11 enabled.
// - Written bits 7:6 select receive trigger level.
// - Auto flow drops request-to-send at trigger level with FIFOs enabled.
// - Receive trigger governs receive DMA request output in DMA mode 1 with FIFOs enabled.
// - Bit rate is clock over sixteen times divisor.
// - Zero divisor stops the baud clock entirely.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
module uie_top
  import uie_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // UART datapath status
  input wire uie_events_t events_i,
  // Interrupt identification
  output logic irq_pending_o,
  output logic [3:0] irq_id_o,
  // Flow control and DMA
  output logic rts_n_o,
  output logic dma_rx_req_n_o,
  // Baud timing
  output logic baud16_tick_o,
  output logic bit_tick_o
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic logic [4:0] rx_threshold(input logic [1:0] sel);
    logic [4:0] lvl;
    case (sel)
      2'b00: lvl = UIE_LVL_ONE;
      2'b01: lvl = UIE_LVL_QUARTER;
      2'b10: lvl = UIE_LVL_HALF;
      default: lvl = UIE_LVL_TWO_BELOW;
    endcase
    return lvl;
  endfunction

  function automatic logic [4:0] tx_threshold(input logic [1:0] sel);
    logic [4:0] lvl;
    case (sel)
      2'b00: lvl = UIE_LVL_EMPTY;
      2'b01: lvl = UIE_LVL_TWO;
      2'b10: lvl = UIE_LVL_QUARTER;
      default: lvl = UIE_LVL_HALF;
    endcase
    return lvl;
  endfunction

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic req;
  logic wr_lane0;
  logic hit_dll, hit_ier, hit_fcr, hit_lcr, hit_flow;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
  assign hit_dll = (wb_adr_i == UIE_ADDR_DIV_LOW);
  assign hit_ier = (wb_adr_i == UIE_ADDR_IER_DLH);
  assign hit_fcr = (wb_adr_i == UIE_ADDR_IIR_FCR);
  assign hit_lcr = (wb_adr_i == UIE_ADDR_LINE_CTRL);
  assign hit_flow = (wb_adr_i == UIE_ADDR_FLOW_CTRL);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] dll_q, dll_d;
  logic [7:0] dlh_q, dlh_d;
  logic [7:0] ier_q, ier_d;
  logic [7:0] lcr_q, lcr_d;
  logic [1:0] flow_q, flow_d;
  uie_fifo_ctrl_t fcr_q, fcr_d;
  logic divisor_access_bit;

  assign divisor_access_bit = lcr_q[UIE_LCR_DIV_ACCESS_BIT];

  always_comb begin
    dll_d = dll_q;
    dlh_d = dlh_q;
    ier_d = ier_q;
    lcr_d = lcr_q;
    flow_d = flow_q;
    fcr_d = fcr_q;
    if (wr_lane0) begin
      // Only lane 0 is stored; bits 31:8 of every register ignore writes.
      if (hit_dll && divisor_access_bit) begin
        dll_d = wb_dat_i[7:0];
      end
      if (hit_ier && divisor_access_bit) begin
        dlh_d = wb_dat_i[7:0];
      end
      if (hit_ier && !divisor_access_bit) begin
        ier_d = wb_dat_i[7:0] & UIE_IER_USED_MASK;
      end
      if (hit_lcr) begin
        lcr_d = wb_dat_i[7:0];
      end
      if (hit_flow) begin
        flow_d = wb_dat_i[1:0];
      end
      if (hit_fcr) begin
        fcr_d.fifo_en = wb_dat_i[UIE_FCR_FIFO_EN_BIT];
        fcr_d.dma_mode = wb_dat_i[UIE_FCR_DMA_MODE_BIT];
        fcr_d.tx_empty_trigger = wb_dat_i[UIE_FCR_TXE_TRIG_LSB +: 2];
        fcr_d.rx_trigger_level = wb_dat_i[UIE_FCR_RX_TRIG_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_q <= UIE_RST_BYTE;
      dlh_q <= UIE_RST_BYTE;
      ier_q <= UIE_RST_BYTE;
      lcr_q <= UIE_RST_BYTE;
      flow_q <= 2'b00;
      fcr_q <= '0;
    end else begin
      dll_q <= dll_d;
      dlh_q <= dlh_d;
      ier_q <= ier_d;
      lcr_q <= lcr_d;
      flow_q <= flow_d;
      fcr_q <= fcr_d;
    end
  end

  // ==========================================================================
  // Interrupt priority
  // ==========================================================================
  logic [4:0] rx_trig;
  logic rx_avail;
  logic tx_holding_empty_src;
  logic [3:0] iid;

  assign rx_trig = rx_threshold(fcr_q.rx_trigger_level);
  // Without FIFOs a single character is enough to raise data-available.
  assign rx_avail = fcr_q.fifo_en ? (events_i.rx_level >= rx_trig) : (events_i.rx_level != 5'h00);
  // In programmable mode the empty condition follows the transmit threshold instead of a bare empty flag.
  assign tx_holding_empty_src = (ier_q[UIE_EN_PROG_TXE_BIT] && fcr_q.fifo_en) ?
                    (events_i.tx_level <= tx_threshold(fcr_q.tx_empty_trigger)) : events_i.tx_holding_empty;

  always_comb begin
    if (ier_q[UIE_IER_LSTAT_BIT] && events_i.line_status) begin
      iid = UIE_IID_LSTAT;
    end else if (ier_q[UIE_IER_RXAV_BIT] && rx_avail) begin
      iid = UIE_IID_RXAV;
    end else if (ier_q[UIE_IER_RXAV_BIT] && fcr_q.fifo_en && events_i.char_timeout) begin
      iid = UIE_IID_TIMEOUT;
    end else if (ier_q[UIE_IER_TX_HOLDING_EMPTY_BIT] && tx_holding_empty_src) begin
      iid = UIE_IID_TX_HOLDING_EMPTY;
    end else if (ier_q[UIE_IER_MODEM_BIT] && events_i.modem_status) begin
      iid = UIE_IID_MODEM;
    end else begin
      iid = UIE_IID_NONE;
    end
  end

  logic [3:0] iid_q;
  logic irq_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iid_q <= UIE_IID_NONE;
      irq_q <= 1'b0;
    end else begin
      iid_q <= iid;
      irq_q <= (iid != UIE_IID_NONE);
    end
  end

  assign irq_id_o = iid_q;
  assign irq_pending_o = irq_q;

  // ==========================================================================
  // Flow control and receive DMA request
  // ==========================================================================
  logic rts_n_q, rts_n_d;
  logic dma_n_q, dma_n_d;
  logic at_trigger;

  assign at_trigger = events_i.rx_level >= rx_trig;

  always_comb begin
    rts_n_d = !flow_q[UIE_FLOW_RTS_BIT];
    if (flow_q[UIE_FLOW_AUTO_BIT] && fcr_q.fifo_en && at_trigger) begin
      rts_n_d = 1'b1;
    end
    // Mode 0 asks whenever data waits; mode 1 asks from the trigger until the FIFO is drained.
    dma_n_d = dma_n_q;
    if (!fcr_q.dma_mode || !fcr_q.fifo_en) begin
      dma_n_d = (events_i.rx_level == 5'h00);
    end else if (at_trigger) begin
      dma_n_d = 1'b0;
    end else if (events_i.rx_level == 5'h00) begin
      dma_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_n_q <= 1'b1;
      dma_n_q <= 1'b1;
    end else begin
      rts_n_q <= rts_n_d;
      dma_n_q <= dma_n_d;
    end
  end

  assign rts_n_o = rts_n_q;
  assign dma_rx_req_n_o = dma_n_q;

  // ==========================================================================
  // Read data and acknowledge
  // ==========================================================================
  logic [31:0] rdata_q, rdata_d;
  logic ack_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_dll) begin
      rdata_d[7:0] = divisor_access_bit ? dll_q : UIE_RST_BYTE;
    end else if (hit_ier) begin
      rdata_d[7:0] = divisor_access_bit ? dlh_q : (ier_q & UIE_IER_USED_MASK);
    end else if (hit_fcr) begin
      rdata_d[7:6] = fcr_q.fifo_en ? UIE_FIFO_STAT_ON : UIE_FIFO_STAT_OFF;
      rdata_d[3:0] = iid;
    end else if (hit_lcr) begin
      rdata_d[7:0] = lcr_q;
    end else if (hit_flow) begin
      rdata_d[1:0] = flow_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= req ? rdata_d : rdata_q;
      ack_q <= req;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;

  // ==========================================================================
  // Baud generator
  // ==========================================================================
  uie_baud_gen u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .divisor_i({dlh_q, dll_q}),
    .baud16_tick_o(baud16_tick_o),
    .bit_tick_o(bit_tick_o)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_dlh_needs_divisor_access_bit: assert property (
    wr_lane0 && hit_ier && !divisor_access_bit |=> $stable(dlh_q))
    else $error("divisor high written without access bit");
  a_prog_tx_empty_irq_mode_bit_kept: assert property (
    wr_lane0 && hit_ier && !divisor_access_bit |=> ier_q[UIE_EN_PROG_TXE_BIT] == $past(wb_dat_i[7]))
    else $error("programmable empty mode bit not stored");
  a_modem_lowest: assert property (
    irq_q && iid_q == UIE_IID_MODEM |-> $past(ier_q[UIE_IER_MODEM_BIT] && !(ier_q[UIE_IER_TX_HOLDING_EMPTY_BIT] && tx_holding_empty_src)))
    else $error("modem interrupt reported out of order");
  a_lstat_first: assert property (
    ier_q[UIE_IER_LSTAT_BIT] && events_i.line_status |=> irq_id_o == UIE_IID_LSTAT)
    else $error("line status not top priority");
  a_tx_holding_empty_gated: assert property (
    !ier_q[UIE_IER_TX_HOLDING_EMPTY_BIT] |=> irq_id_o != UIE_IID_TX_HOLDING_EMPTY)
    else $error("tx empty interrupt while disabled");
  a_rxav_gated: assert property (
    !ier_q[UIE_IER_RXAV_BIT] |=> irq_id_o != UIE_IID_RXAV && irq_id_o != UIE_IID_TIMEOUT)
    else $error("data interrupt while disabled");
  a_reserved_zero: assert property (
    req && hit_ier && !divisor_access_bit |=> wb_ack_o && wb_dat_o[6:4] == 3'b000 && wb_dat_o[31:8] == 24'h00_0000)
    else $error("reserved enable bits read nonzero");
  a_fifos_enabled_status_read: assert property (
    req && hit_fcr |=> wb_dat_o[7:6] == ($past(fcr_q.fifo_en) ? UIE_FIFO_STAT_ON : UIE_FIFO_STAT_OFF))
    else $error("fifo status field wrong");
  a_rt_quarter: assert property (
    fcr_q.rx_trigger_level == 2'b01 |-> rx_trig == UIE_LVL_QUARTER)
    else $error("quarter trigger level wrong");
  a_rts_at_trig: assert property (
    flow_q[UIE_FLOW_AUTO_BIT] && fcr_q.fifo_en && at_trigger |=> rts_n_o)
    else $error("rts still asserted at trigger");
  a_dma_mode1: assert property (
    fcr_q.dma_mode && fcr_q.fifo_en && at_trigger |=> !dma_rx_req_n_o)
    else $error("dma request missing at trigger");
  a_reset_clear: assert property (
    $past(rst_i) |-> ier_q == 8'h00 && dlh_q == 8'h00)
    else $error("enables not cleared by reset");

endmodule

/* rtl/uie_pkg.sv */
// Package holding register map, field layout, reset values and types of the UART enable/FIFO-control block.
package uie_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [31:0] UIE_ADDR_DIV_LOW = 32'h5000_1100;
  localparam logic [31:0] UIE_ADDR_IER_DLH = 32'h5000_1104;
  localparam logic [31:0] UIE_ADDR_IIR_FCR = 32'h5000_1108;
  localparam logic [31:0] UIE_ADDR_LINE_CTRL = 32'h5000_110C;
  localparam logic [31:0] UIE_ADDR_FLOW_CTRL = 32'h5000_1110;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int UIE_LCR_DIV_ACCESS_BIT = 7;
  localparam int UIE_EN_PROG_TXE_BIT = 7;
  localparam int UIE_IER_MODEM_BIT = 3;
  localparam int UIE_IER_LSTAT_BIT = 2;
  localparam int UIE_IER_TX_HOLDING_EMPTY_BIT = 1;
  localparam int UIE_IER_RXAV_BIT = 0;
  localparam int UIE_FCR_FIFO_EN_BIT = 0;
  localparam int UIE_FCR_DMA_MODE_BIT = 3;
  localparam int UIE_FCR_TXE_TRIG_LSB = 4;
  localparam int UIE_FCR_RX_TRIG_LSB = 6;
  localparam int UIE_FLOW_RTS_BIT = 0;
  localparam int UIE_FLOW_AUTO_BIT = 1;

  // ==========================================================================
  // Reset values and field masks
  // ==========================================================================
  localparam logic [7:0] UIE_RST_BYTE = 8'h00;
  localparam logic [7:0] UIE_IER_USED_MASK = 8'h8F;
  localparam logic [1:0] UIE_FIFO_STAT_ON = 2'b11;
  localparam logic [1:0] UIE_FIFO_STAT_OFF = 2'b00;

  // ==========================================================================
  // FIFO levels and thresholds (depth 16)
  // ==========================================================================
  localparam logic [4:0] UIE_LVL_ONE = 5'h01;
  localparam logic [4:0] UIE_LVL_QUARTER = 5'h04;
  localparam logic [4:0] UIE_LVL_HALF = 5'h08;
  localparam logic [4:0] UIE_LVL_TWO_BELOW = 5'h0E;
  localparam logic [4:0] UIE_LVL_EMPTY = 5'h00;
  localparam logic [4:0] UIE_LVL_TWO = 5'h02;

  // ==========================================================================
  // Interrupt identification codes
  // ==========================================================================
  localparam logic [3:0] UIE_IID_NONE = 4'h1;
  localparam logic [3:0] UIE_IID_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [3:0] UIE_IID_RXAV = 4'h4;
  localparam logic [3:0] UIE_IID_LSTAT = 4'h6;
  localparam logic [3:0] UIE_IID_TIMEOUT = 4'hC;
  localparam logic [3:0] UIE_IID_MODEM = 4'h0;

  // ==========================================================================
  // Baud generation
  // ==========================================================================
  localparam logic [3:0] UIE_OVERSAMPLE_LAST = 4'hF;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic line_status;
    logic char_timeout;
    logic modem_status;
    logic tx_holding_empty;
    logic [4:0] rx_level;
    logic [4:0] tx_level;
  } uie_events_t;

  typedef struct packed {
    logic fifo_en;
    logic dma_mode;
    logic [1:0] tx_empty_trigger;
    logic [1:0] rx_trigger_level;
  } uie_fifo_ctrl_t;

endpackage

/* rtl/uie_baud_gen.sv */
// Baud generator: divides the serial clock by the 16-bit divisor and by sixteen.
`timescale 1ns/10ps
module uie_baud_gen
  import uie_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Divisor
  input wire logic [15:0] divisor_i,
  // Ticks
  output logic baud16_tick_o,
  output logic bit_tick_o
);

  // ==========================================================================
  // Counters
  // ==========================================================================
  logic [15:0] div_cnt_q, div_cnt_d;
  logic [3:0] os_cnt_q, os_cnt_d;
  logic b16_q, b16_d;
  logic bit_q, bit_d;
  logic running;

  // A zero divisor stops the counters, so no tick ever leaves the block.
  assign running = (divisor_i != 16'h0000);

  always_comb begin
    div_cnt_d = div_cnt_q;
    os_cnt_d = os_cnt_q;
    b16_d = 1'b0;
    bit_d = 1'b0;
    if (!running) begin
      div_cnt_d = 16'h0000;
      os_cnt_d = 4'h0;
    end else if (div_cnt_q >= divisor_i - 16'h0001) begin
      div_cnt_d = 16'h0000;
      b16_d = 1'b1;
      os_cnt_d = os_cnt_q + 4'h1;
      bit_d = (os_cnt_q == UIE_OVERSAMPLE_LAST);
    end else begin
      div_cnt_d = div_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_q <= 16'h0000;
      os_cnt_q <= 4'h0;
      b16_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      os_cnt_q <= os_cnt_d;
      b16_q <= b16_d;
      bit_q <= bit_d;
    end
  end

  assign baud16_tick_o = b16_q;
  assign bit_tick_o = bit_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_zero_div_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    (divisor_i == 16'h0000) ##1 (divisor_i == 16'h0000) |-> !b16_q && !bit_q)
    else $error("baud tick while divisor is zero");
  a_div_one_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    (divisor_i == 16'h0001) [*3] |-> b16_q)
    else $error("divisor one does not tick every cycle");

endmodule

/* test/uie_sw_model.sv */
// Software model: classic single Wishbone cycles issued by the processor.
`timescale 1ns/10ps
module uie_sw_model
  import uie_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [31:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 32'h0000_0000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // One request held until ack is sampled; ok stays low if no ack comes.
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= wd;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        rd = wb_dat_i;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    // Released data must not look like a still-valid value.
    wb_dat_o <= ~wd;
    if (we && (adr == UIE_ADDR_DIV_LOW || adr == UIE_ADDR_IER_DLH)) begin
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule

/* test/testbench.sv */
// Self-checking testbench of the enable, divisor-high and FIFO-control block.
`timescale 1ns/10ps
module testbench
  import uie_pkg::*;
;
  logic clk_i;
  logic rst_i;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0] wb_sel;
  logic [31:0] wb_adr, wb_wd, wb_rd;
  uie_events_t ev;
  logic pend, rts_n, dma_n, b16, btick;
  logic [3:0] iid;
  int n_errors = 0;
  int samples_checked = 0;

  // ==========================================================================
  // Instances
  // ==========================================================================
  uie_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .events_i(ev), .irq_pending_o(pend), .irq_id_o(iid), .rts_n_o(rts_n), .dma_rx_req_n_o(dma_n),
    .baud16_tick_o(b16), .bit_tick_o(btick));
  uie_sw_model u_sw (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wd), .wb_dat_i(wb_rd), .wb_ack_i(wb_ack));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic we, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] r);
    logic ok;
    u_sw.xfer(we, a, s, d, r, ok);
    if (!ok) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, 4'hF, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, a, 4'hF, 32'h0000_0000, r);
    chk(r & m, e);
  endtask

  task automatic st_chk(input logic [3:0] id, input logic p, input logic rt, input logic dm);
    chk({25'h000_0000, iid, pend, rts_n, dma_n}, {25'h000_0000, id, p, rt, dm});
  endtask

  task automatic set_ev(input uie_events_t e);
    @(posedge clk_i);
    ev <= e;
    repeat (3) @(posedge clk_i);
  endtask

  // Cycles between two consecutive ticks of the chosen output.
  task automatic tick_gap(input logic use_bit, output int gap);
    int n;
    for (n = 0; n < 40000 && (use_bit ? btick : b16) !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    for (gap = 1; gap < 40000 && (use_bit ? btick : b16) !== 1'b1; gap++) @(posedge clk_i);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_reset();
    rd_chk(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(UIE_ADDR_IIR_FCR, 32'h0000_00C0, 32'h0000_0000);
    rd_chk(32'h5000_1200, 32'hFFFF_FFFF, 32'h0000_0000);
    st_chk(UIE_IID_NONE, 1'b0, 1'b1, 1'b1);
    $display("test_reset done, errors %0d", n_errors);
  endtask

  task automatic test_enables();
    logic [7:0] en [5] = '{8'h0F, 8'h0B, 8'h0A, 8'h08, 8'h00};
    logic [3:0] id [5] = '{UIE_IID_LSTAT, UIE_IID_RXAV, UIE_IID_TX_HOLDING_EMPTY, UIE_IID_MODEM, UIE_IID_NONE};
    logic [31:0] r;
    wr(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF);
    rd_chk(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF, 32'h0000_008F);
    acc(1'b1, UIE_ADDR_IER_DLH, 4'h0, 32'h0000_0000, r);
    rd_chk(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF, 32'h0000_008F);
    set_ev('{1'b1, 1'b0, 1'b1, 1'b1, 5'h01, 5'h00});
    for (int i = 0; i < 5; i++) begin
      wr(UIE_ADDR_IER_DLH, {24'h00_0000, en[i]});
      repeat (3) @(posedge clk_i);
      st_chk(id[i], id[i] != UIE_IID_NONE, 1'b1, 1'b0);
    end
    wr(UIE_ADDR_IIR_FCR, 32'h0000_0001);
    wr(UIE_ADDR_IER_DLH, 32'h0000_0001);
    set_ev('{1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 5'h00});
    st_chk(UIE_IID_TIMEOUT, 1'b1, 1'b1, 1'b1);
    wr(UIE_ADDR_IER_DLH, 32'h0000_0082);
    set_ev('{1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 5'h00});
    st_chk(UIE_IID_TX_HOLDING_EMPTY, 1'b1, 1'b1, 1'b1);
    set_ev('{1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 5'h01});
    st_chk(UIE_IID_NONE, 1'b0, 1'b1, 1'b1);
    $display("test_enables done, errors %0d", n_errors);
  endtask

  task automatic test_divisor();
    int gap;
    int cnt;
    wr(UIE_ADDR_LINE_CTRL, 32'h0000_0080);
    rd_chk(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF, 32'h0000_0000);
    cnt = 0;
    repeat (300) begin
      @(posedge clk_i);
      if (btick !== 1'b0 || b16 !== 1'b0) cnt++;
    end
    chk(cnt, 0);
    wr(UIE_ADDR_IER_DLH, 32'h0000_0071);
    wr(UIE_ADDR_DIV_LOW, 32'h0000_0002);
    rd_chk(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF, 32'h0000_0071);
    tick_gap(1'b0, gap);
    chk(gap, 32'h0000_7102);
    wr(UIE_ADDR_IER_DLH, 32'h0000_0001);
    tick_gap(1'b1, gap);
    chk(gap, 16 * 32'h0000_0102);
    wr(UIE_ADDR_LINE_CTRL, 32'h0000_0000);
    rd_chk(UIE_ADDR_IER_DLH, 32'hFFFF_FFFF, 32'h0000_0082);
    $display("test_divisor done, errors %0d", n_errors);
  endtask

  task automatic test_fifo();
    logic [4:0] thr [4] = '{UIE_LVL_ONE, UIE_LVL_QUARTER, UIE_LVL_HALF, UIE_LVL_TWO_BELOW};
    wr(UIE_ADDR_FLOW_CTRL, 32'h0000_0003);
    wr(UIE_ADDR_IER_DLH, 32'h0000_0001);
    for (int t = 0; t < 4; t++) begin
      wr(UIE_ADDR_IIR_FCR, {24'h00_0000, t[1:0], 6'h09});
      rd_chk(UIE_ADDR_IIR_FCR, 32'h0000_00C0, 32'h0000_00C0);
      set_ev('{1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 5'h00});
      set_ev('{1'b0, 1'b0, 1'b0, 1'b0, thr[t] - 5'h01, 5'h00});
      st_chk(UIE_IID_NONE, 1'b0, 1'b0, 1'b1);
      set_ev('{1'b0, 1'b0, 1'b0, 1'b0, thr[t], 5'h00});
      st_chk(UIE_IID_RXAV, 1'b1, 1'b1, 1'b0);
    end
    wr(UIE_ADDR_IIR_FCR, 32'h0000_0000);
    rd_chk(UIE_ADDR_IIR_FCR, 32'h0000_00C0, 32'h0000_0000);
    $display("test_fifo done, errors %0d", n_errors);
  endtask

  // ==========================================================================
  // Clock, reset and main sequence
  // ==========================================================================
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    ev = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_enables();
    test_divisor();
    test_fifo();
    complete_run();
  end
endmodule
